// [core/dcm_defines.vh]
`ifndef DCM_DEFINES_VH
`define DCM_DEFINES_VH

// ==========================================================
// Register indices; byte address is four times the index
`define DCM_IDX_ADDR_HIGH       6'h29
`define DCM_IDX_ADDR_MID        6'h2a
`define DCM_IDX_ADDR_LOW        6'h2b
`define DCM_IDX_DATA_HIGH       6'h2c
`define DCM_IDX_DATA_LOW        6'h2d
`define DCM_IDX_DATA_HIGH_MASK  6'h2e

// ==========================================================
// Comparator select encodings
`define DCM_SEL_FIRST           2'b00
`define DCM_SEL_SECOND          2'b01
`define DCM_SEL_THIRD           2'b10
`define DCM_SEL_NONE            2'b11

// ==========================================================
// Field layout and reset values
`define DCM_ADDR_HIGH_W         2
`define DCM_ADDR_W              18
`define DCM_DATA_W              16
`define DCM_NUM_CMP             3
`define DCM_RST_ADDR_HIGH       2'h0
`define DCM_RST_BYTE            8'h00

// ==========================================================
// AHB encodings
`define DCM_HTRANS_NONSEQ_BIT   1
`define DCM_HRESP_OKAY          1'b0

`endif

// [core/dcm_match_regs.v]
`timescale 1ns/1ps
`include "dcm_defines.vh"

// Contract
// - Mid register sets expected address bits 15:8
// - Low register sets expected address bits 7:0
// - Address registers readable unless select is 11; writes only disarmed
// - Data registers readable only when select is 00
// - Data writes need select 00 and disarmed
// - Data high holds expected data bits 15:8
// - Data low holds expected data bits 7:0
// - Data bit compared only when mask is 1
// - Data compare skipped while tagging is set
// - Only first comparator has data compare
// - High mask 0 makes data bit don't-care
// - Select field picks visible comparator; 11 none
// - High register sets expected address bits 17:16
module dcm_match_regs (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire [1:0]  comparator_select_field,
  input  wire        debug_unit_armed,
  input  wire        first_comparator_tag,
  input  wire [7:0]  data_low_mask,
  input  wire        cpu_access,
  input  wire [17:0] cpu_addr,
  input  wire [15:0] cpu_data,
  output reg  [2:0]  match
);

  // ==========================================================
  // Bus address phase capture
  reg        wr_pend_q;
  reg        rd_pend_q;
  reg [5:0]  idx_q;
  reg        inwin_q;
  wire       take;
  wire       hit;

  assign take = hsel & hready & htrans[`DCM_HTRANS_NONSEQ_BIT];
  // Anything outside the low window is unmapped and reads zero
  assign hit  = (haddr[31:8] == 24'h000000);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q     <= 6'h00;
      inwin_q   <= 1'b0;
    end else begin
      wr_pend_q <= take & hwrite;
      rd_pend_q <= take & ~hwrite;
      if (take) begin
        idx_q   <= haddr[7:2];
        inwin_q <= hit;
      end
    end
  end

  // ==========================================================
  // Write qualification
  wire [7:0] wbyte;
  wire       wr_ok;
  wire       data_ok_sel;

  wire       wr_addr_high;
  wire       wr_addr_mid;
  wire       wr_addr_low;
  wire       wr_data_high;
  wire       wr_data_low;
  wire       wr_data_mask;

  assign wbyte       = hwdata[7:0];
  assign wr_ok       = wr_pend_q & inwin_q & ~debug_unit_armed;
  assign data_ok_sel = (comparator_select_field == `DCM_SEL_FIRST);

  // Address strobes; each comparator adds its own select term
  assign wr_addr_high = wr_ok & (idx_q == `DCM_IDX_ADDR_HIGH);
  assign wr_addr_mid  = wr_ok & (idx_q == `DCM_IDX_ADDR_MID);
  assign wr_addr_low  = wr_ok & (idx_q == `DCM_IDX_ADDR_LOW);

  // Data strobes need select 00, so any other select drops the byte
  assign wr_data_high = wr_ok & data_ok_sel & (idx_q == `DCM_IDX_DATA_HIGH);
  assign wr_data_low  = wr_ok & data_ok_sel & (idx_q == `DCM_IDX_DATA_LOW);
  assign wr_data_mask = wr_ok & data_ok_sel & (idx_q == `DCM_IDX_DATA_HIGH_MASK);

  // ==========================================================
  // Per comparator address registers and match
  wire [`DCM_ADDR_W-1:0] cmp_addr [0:`DCM_NUM_CMP-1];
  wire [2:0]             hit_vec;

  // Data registers of the first comparator
  reg  [7:0] data_high_q;
  reg  [7:0] data_low_q;
  reg  [7:0] data_high_mask_q;
  wire [15:0] dmask;
  wire [15:0] dexp;
  wire        data_match;

  genvar g;
  generate
    for (g = 0; g < `DCM_NUM_CMP; g = g + 1) begin : g_cmp
      reg  [1:0] addr_high_q;
      reg  [7:0] addr_mid_q;
      reg  [7:0] addr_low_q;
      wire       sel_me;

      assign sel_me = ({30'h00000000, comparator_select_field} == g);
      assign cmp_addr[g] = {addr_high_q, addr_mid_q, addr_low_q};

      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          addr_high_q <= `DCM_RST_ADDR_HIGH;
        end else if (wr_addr_high && sel_me) begin
          addr_high_q <= wbyte[1:0];
        end
      end

      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          addr_mid_q <= `DCM_RST_BYTE;
        end else if (wr_addr_mid && sel_me) begin
          addr_mid_q <= wbyte;
        end
      end

      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          addr_low_q <= `DCM_RST_BYTE;
        end else if (wr_addr_low && sel_me) begin
          addr_low_q <= wbyte;
        end
      end

      // Only comparator zero looks at the data bus
      if (g == 0) begin : g_data
        assign hit_vec[g] = (cpu_addr == cmp_addr[g]) & data_match;
      end else begin : g_addr
        assign hit_vec[g] = (cpu_addr == cmp_addr[g]);
      end
    end
  endgenerate

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_high_q <= `DCM_RST_BYTE;
    end else if (wr_data_high) begin
      data_high_q <= wbyte;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_low_q <= `DCM_RST_BYTE;
    end else if (wr_data_low) begin
      data_low_q <= wbyte;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_high_mask_q <= `DCM_RST_BYTE;
    end else if (wr_data_mask) begin
      data_high_mask_q <= wbyte;
    end
  end

  // ==========================================================
  // Data comparison
  assign dmask = {data_high_mask_q, data_low_mask};
  assign dexp  = {data_high_q, data_low_q};
  // Tagging makes the match depend on address alone
  assign data_match = first_comparator_tag |
                      (((cpu_data ^ dexp) & dmask) == 16'h0000);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match <= 3'h0;
    end else begin
      match <= {3{cpu_access}} & hit_vec;
    end
  end

  // ==========================================================
  // Read mux
  reg [7:0] rsel;
  reg [1:0] rh;
  reg [7:0] rm;
  reg [7:0] rl;

  always @* begin
    rh = 2'h0;
    rm = 8'h00;
    rl = 8'h00;
    case (comparator_select_field)
      `DCM_SEL_FIRST: begin
        rh = cmp_addr[0][17:16];
        rm = cmp_addr[0][15:8];
        rl = cmp_addr[0][7:0];
      end
      `DCM_SEL_SECOND: begin
        rh = cmp_addr[1][17:16];
        rm = cmp_addr[1][15:8];
        rl = cmp_addr[1][7:0];
      end
      `DCM_SEL_THIRD: begin
        rh = cmp_addr[2][17:16];
        rm = cmp_addr[2][15:8];
        rl = cmp_addr[2][7:0];
      end
      default: begin
        rh = 2'h0;
      end
    endcase
    rsel = 8'h00;
    if (inwin_q) begin
      case (idx_q)
        `DCM_IDX_ADDR_HIGH:      rsel = {6'h00, rh};
        `DCM_IDX_ADDR_MID:       rsel = rm;
        `DCM_IDX_ADDR_LOW:       rsel = rl;
        `DCM_IDX_DATA_HIGH:      rsel = data_ok_sel ? data_high_q : 8'h00;
        `DCM_IDX_DATA_LOW:       rsel = data_ok_sel ? data_low_q : 8'h00;
        `DCM_IDX_DATA_HIGH_MASK: rsel = data_ok_sel ? data_high_mask_q : 8'h00;
        default:                 rsel = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Read answer
  // One wait state so a read right after a write sees the new value
  // Low only in the first data cycle of a read
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else if (take && !hwrite) begin
      hreadyout <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  // Held until the next read completes
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_pend_q) begin
      hrdata <= {24'h000000, rsel};
    end
  end

  // No error responses exist in this block
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= `DCM_HRESP_OKAY;
    end else begin
      hresp <= `DCM_HRESP_OKAY;
    end
  end

endmodule // dcm_match_regs

// [sim/dcm_cpu_model.sv]
`timescale 1ns/1ps
// ==========================================
// CPU bus model; released lines invert so stale values never match
module dcm_cpu_model (
  input  logic        hclk,
  output logic        cpu_access,
  output logic [17:0] cpu_addr,
  output logic [15:0] cpu_data
);
  initial begin
    cpu_access = 1'b0;
    cpu_addr   = 18'h0;
    cpu_data   = 16'h0;
  end
  task put(input logic [17:0] a, input logic [15:0] d);
    @(posedge hclk);
    cpu_access <= 1'b1;
    cpu_addr   <= a;
    cpu_data   <= d;
    @(posedge hclk);
    cpu_access <= 1'b0;
    cpu_addr   <= ~a;
    cpu_data   <= ~d;
  endtask
endmodule // dcm_cpu_model

// [sim/dcm_match_regs_sva.sv]
`timescale 1ns/1ps
// ==========================================
// Bus and match checks
module dcm_match_regs_sva (
  input logic        hclk,
  input logic        hresetn,
  input logic        hsel,
  input logic [31:0] haddr,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic        hready,
  input logic        hreadyout,
  input logic        hresp,
  input logic [31:0] hrdata,
  input logic [1:0]  comparator_select_field,
  input logic        cpu_access,
  input logic [2:0]  match
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire rd = hsel && hready && htrans[1] && !hwrite;
  wire wr = hsel && hready && htrans[1] && hwrite;
  chk_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
  chk_read_wait: assert property (rd |=> !hreadyout ##1 hreadyout) else $error("read wait");
  chk_write_nowait: assert property (wr |=> hreadyout) else $error("write waited");
  chk_wait_once: assert property (!hreadyout |=> hreadyout) else $error("long wait");
  chk_match_idle: assert property (!cpu_access |=> match == 3'b000)
    else $error("match without access");
  chk_data_hidden: assert property (rd && haddr[7:0] >= 8'hb0 && haddr[7:0] <= 8'hb8
    && comparator_select_field != 2'b00 |=> ##1 hrdata == 32'h0) else $error("data visible");
  chk_upper_zero: assert property (hrdata[31:8] == 24'h0) else $error("upper bits set");
  chk_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("hrdata moved");
endmodule // dcm_match_regs_sva
bind dcm_match_regs dcm_match_regs_sva dcm_match_regs_sva_inst (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .comparator_select_field(comparator_select_field), .cpu_access(cpu_access), .match(match));

// [sim/dcm_match_regs_tb_top.sv]
`timescale 1ns/1ps
`include "dcm_defines.vh"
// ==========================================
// Bench top
module dcm_match_regs_tb_top;
  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'b00;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic [1:0]  sel     = 2'b00;
  logic        armed   = 1'b0;
  logic        tag     = 1'b0;
  logic [7:0]  dlm     = 8'hff;
  logic [7:0]  lv [6]  = '{8'h02, 8'ha5, 8'h3c, 8'h12, 8'h34, 8'hff};
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, cpu_access;
  wire  [17:0] cpu_addr;
  wire  [15:0] cpu_data;
  wire  [2:0]  match;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  dcm_match_regs dcm_match_regs_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .comparator_select_field(sel), .debug_unit_armed(armed), .first_comparator_tag(tag),
    .data_low_mask(dlm), .cpu_access(cpu_access), .cpu_addr(cpu_addr),
    .cpu_data(cpu_data), .match(match));
  dcm_cpu_model dcm_cpu_model_inst (.hclk(hclk), .cpu_access(cpu_access),
    .cpu_addr(cpu_addr), .cpu_data(cpu_data));
  initial forever #20 hclk = ~hclk;
  task end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Read compares against v; write stores v
  task x(input logic w, input logic [5:0] i, input logic [7:0] v);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h0, i, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, v};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    if (!w) cmp(hrdata, {24'h0, v});
  endtask
  task m(input logic [17:0] a, input logic [15:0] d, input logic [2:0] e);
    dcm_cpu_model_inst.put(a, d);
    #1 cmp({29'h0, match}, {29'h0, e});
  endtask
  // Hang guard; run needs well under this
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      end_sim;
    end
  end
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 6; i++) x(1'b0, 6'h29 + i[5:0], 8'h00);
    x(1'b0, 6'h3f, 8'h00);
    for (int i = 0; i < 6; i++) x(1'b1, 6'h29 + i[5:0], lv[i]);
    for (int i = 0; i < 6; i++) x(1'b0, 6'h29 + i[5:0], lv[i]);
    armed <= 1'b1;
    x(1'b1, `DCM_IDX_ADDR_MID, 8'hff);
    x(1'b1, `DCM_IDX_DATA_LOW, 8'hff);
    x(1'b0, `DCM_IDX_ADDR_MID, 8'ha5);
    x(1'b0, `DCM_IDX_DATA_LOW, 8'h34);
    armed <= 1'b0;
    sel <= `DCM_SEL_SECOND;
    x(1'b0, `DCM_IDX_DATA_HIGH, 8'h00);
    x(1'b1, `DCM_IDX_DATA_LOW, 8'h77);
    x(1'b1, `DCM_IDX_ADDR_HIGH, 8'h01);
    x(1'b1, `DCM_IDX_ADDR_MID, 8'h11);
    x(1'b1, `DCM_IDX_ADDR_LOW, 8'h22);
    x(1'b0, `DCM_IDX_ADDR_MID, 8'h11);
    sel <= `DCM_SEL_THIRD;
    for (int i = 0; i < 3; i++) x(1'b1, 6'h29 + i[5:0], lv[i]);
    sel <= `DCM_SEL_NONE;
    x(1'b1, `DCM_IDX_ADDR_MID, 8'h99);
    x(1'b0, `DCM_IDX_ADDR_MID, 8'h00);
    sel <= `DCM_SEL_FIRST;
    x(1'b0, `DCM_IDX_ADDR_MID, 8'ha5);
    x(1'b0, `DCM_IDX_DATA_LOW, 8'h34);
    m(18'h2a53c, 16'h1234, 3'b101);
    m(18'h2a53c, 16'h1235, 3'b100);
    dlm <= 8'hfe;
    m(18'h2a53c, 16'h1235, 3'b101);
    x(1'b1, `DCM_IDX_DATA_HIGH_MASK, 8'h0f);
    m(18'h2a53c, 16'hf234, 3'b101);
    m(18'h2a53c, 16'h1334, 3'b100);
    tag <= 1'b1;
    m(18'h2a53c, 16'h0000, 3'b101);
    m(18'h11122, 16'h0000, 3'b010);
    m(18'h3a53c, 16'h0000, 3'b000);
    end_sim;
  end
endmodule // dcm_match_regs_tb_top
